// File: inc/xcvr_pkg.sv
// constants shared by the transceiver fault logic and its controller end
// assumes one 20 MHz clock on both ends and a digital model of the bus
package xcvr_pkg;
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned CODE_W          = 6;
   localparam int unsigned ARM_EDGES       = 100;
   localparam int unsigned SHIFT_EDGES     = 16;
   localparam int unsigned CLEAR_EDGES     = 10;
   localparam int unsigned MISMATCH_CYCLES = 10;
   localparam int unsigned CNT_W           = 8;
   // times in microseconds, counts rounded down to whole cycles
   localparam int unsigned DOMINANT_TIMEOUT_US = 1000;
   localparam int unsigned WAKE_FILTER_US      = 1;
   localparam int unsigned DOM_CYCLES  = DOMINANT_TIMEOUT_US * (CLK_HZ / 1_000_000);
   localparam int unsigned WAKE_CYCLES = WAKE_FILTER_US * (CLK_HZ / 1_000_000);
   localparam int unsigned TMR_W       = 16;
   localparam logic [5:0] CODE_OVERCURRENT = 6'h2A;
   localparam logic [5:0] CODE_OVERVOLTAGE = 6'h2C;
   localparam logic [5:0] CODE_TX_FAILURE  = 6'h32;
   localparam logic [5:0] CODE_RESET       = 6'h00;
   // controller command register offsets (byte addresses)
   localparam logic [3:0] OFS_CTRL   = 4'h0;
   localparam logic [3:0] OFS_STATUS = 4'h4;
   localparam logic [3:0] OFS_CODE   = 4'h8;
   localparam int unsigned CTRL_ARM   = 0;
   localparam int unsigned CTRL_READ  = 1;
   localparam int unsigned CTRL_CLEAR = 2;
   localparam int unsigned CTRL_STANDBY  = 3;
   localparam int unsigned CTRL_SIL      = 4;
   localparam int unsigned CTRL_LOOPBACK = 5;
   localparam int unsigned CTRL_TXD   = 6;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0040;
   localparam int unsigned HALF_PERIOD = 2;
   typedef enum logic [1:0] {F_IDLE, F_SHIFT, F_CLEAR} fault_state_t;
   typedef enum logic [2:0] {C_IDLE, C_ARM, C_READ, C_CLEAR, C_WAIT} ctl_state_t;
endpackage

// File: inc/xcvr_if.sv
// logic-side and bus-side pins of the transceiver
// assumes the bench resolves the bus lines from the two enables
`timescale 1ns/1ps
interface xcvr_if;
   logic txd;             // transmit data, controller to device
   logic rxd;             // receive data, device to controller
   logic fault;           // fault indicator
   logic standby_select;  // standby mode
   logic silent_select;   // silent mode
   logic loopback_select; // loopback mode
   logic bus_dominant_in; // sensed bus level, 1 = dominant
   logic bus_dominant_out;// driver requests dominant
   logic bus_oe;          // device drives the bus lines
   logic overcurrent;     // analog overcurrent comparator
   logic overvoltage;     // analog overvoltage comparator
   modport device (input txd, standby_select, silent_select, loopback_select,
                   bus_dominant_in, overcurrent, overvoltage,
                   output rxd, fault, bus_dominant_out, bus_oe);
   modport ctrl (output txd, standby_select, silent_select, loopback_select,
                 input rxd, fault);
endinterface

// File: hw/xcvr_device.sv
// transceiver end: modes, dominant timeout, fault detection and reporting
// assumes pins and comparators arrive asynchronous to core_clk
//
// Implementation choices: the placing of the registers.
`timescale 1ns/1ps
module xcvr_device
   import xcvr_pkg::*;
(
   input  wire logic core_clk,  // 20 MHz clock
   input  wire logic arst_n,    // async reset, active low
   xcvr_if.device    pins,      // controller and bus pins
   output logic      fault_pending // user side: fault latched
);
   import xcvr_pkg::*;

   logic [1:0] s_txd, s_stb, s_sil, s_lpb, s_bus, s_oc, s_ov;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_txd <= 2'h3; s_stb <= 2'h0; s_sil <= 2'h0; s_lpb <= 2'h0;
         s_bus <= 2'h0; s_oc <= 2'h0; s_ov <= 2'h0;
      end else begin
         s_txd <= {s_txd[0], pins.txd};
         s_stb <= {s_stb[0], pins.standby_select};
         s_sil <= {s_sil[0], pins.silent_select};
         s_lpb <= {s_lpb[0], pins.loopback_select};
         s_bus <= {s_bus[0], pins.bus_dominant_in};
         s_oc  <= {s_oc[0], pins.overcurrent};
         s_ov  <= {s_ov[0], pins.overvoltage};
      end
   end
   wire txd = s_txd[1];
   wire standby = s_stb[1];
   wire sil = s_sil[1];
   wire loopback = s_lpb[1];
   wire bus_dom = s_bus[1];

   logic txd_q;
   logic armed;
   logic [CNT_W-1:0] cnt;
   logic [3:0] mis_cnt;
   logic [5:0] code;
   logic [5:0] shreg;
   logic [TMR_W-1:0] dom_tmr, wake_tmr;
   logic dom_off;
   logic rxd_q;
   fault_state_t st;

   wire txd_rise  = txd & ~txd_q;
   wire normal    = ~standby & ~sil & ~loopback;
   wire detect_on = normal & armed & (st == F_IDLE);
   wire rx_bus    = ~bus_dom;
   wire mismatch  = (rx_bus != txd) & detect_on;
   wire tx_fail   = (mis_cnt == 4'(MISMATCH_CYCLES - 1)) & mismatch;
   // priority picks one code when causes coincide
   wire [5:0] new_code = s_oc[1] ? CODE_OVERCURRENT :
                         s_ov[1] ? CODE_OVERVOLTAGE :
                         CODE_TX_FAILURE;
   wire new_fault = detect_on & (s_oc[1] | s_ov[1] | tx_fail);
   wire last_shift = (cnt == CNT_W'(SHIFT_EDGES - 1));
   wire last_clear = (cnt == CNT_W'(CLEAR_EDGES - 1));

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         txd_q <= 1'b1;
         armed <= 1'b0;
         cnt <= '0;
         mis_cnt <= '0;
         code <= CODE_RESET;
         shreg <= CODE_RESET;
         st <= F_IDLE;
      end else begin
         txd_q <= txd;
         mis_cnt <= mismatch ? mis_cnt + 4'h1 : 4'h0;
         case (st)
            F_IDLE: begin
               if (!normal) begin
                  cnt <= '0;
               end else if (new_fault) begin
                  code <= new_code;
                  shreg <= new_code;
                  cnt <= '0;
                  st <= F_SHIFT;
               end else if (!armed && txd_rise) begin
                  if (cnt == CNT_W'(ARM_EDGES - 1)) begin
                     armed <= 1'b1;
                     cnt <= '0;
                  end else begin
                     cnt <= cnt + 8'h01;
                  end
               end
            end
            F_SHIFT: begin
               if (!normal) begin
                  cnt <= '0;
               end else if (txd_rise) begin
                  shreg <= {shreg[4:0], 1'b1};
                  cnt <= last_shift ? '0 : cnt + 8'h01;
                  if (last_shift) st <= F_CLEAR;
               end
            end
            F_CLEAR: begin
               if (!normal) begin
                  cnt <= '0;
               end else if (txd_rise) begin
                  cnt <= last_clear ? '0 : cnt + 8'h01;
                  if (last_clear) begin
                     st <= F_IDLE;
                     armed <= 1'b0;
                  end
               end
            end
            default: st <= F_IDLE;
         endcase
      end
   end

   // dominant timeout and wake filter
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         dom_tmr <= '0;
         dom_off <= 1'b0;
         wake_tmr <= '0;
      end else begin
         if (txd) dom_tmr <= '0;
         else if (dom_tmr != TMR_W'(DOM_CYCLES)) dom_tmr <= dom_tmr + 16'h0001;
         if (txd_rise) dom_off <= 1'b0;
         else if (dom_tmr == TMR_W'(DOM_CYCLES)) dom_off <= 1'b1;
         if (!bus_dom) wake_tmr <= '0;
         else if (wake_tmr != TMR_W'(WAKE_CYCLES)) wake_tmr <= wake_tmr + 16'h0001;
      end
   end

   wire pending = (st != F_IDLE);
   wire drive_on = ~pending & ~standby & ~sil & ~loopback & ~dom_off;
   wire standby_rx = ~(wake_tmr == TMR_W'(WAKE_CYCLES));
   // while in F_SHIFT, rx carries the code msb; else mode selects source
   wire next_rxd = (st == F_SHIFT) ? shreg[5] :
                   loopback ? (txd | dom_off) :
                   standby ? standby_rx : rx_bus;
   logic oe_q, dom_q, fault_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         rxd_q <= 1'b1;
         oe_q <= 1'b0;
         dom_q <= 1'b0;
         fault_q <= 1'b0;
      end else begin
         rxd_q <= next_rxd;
         oe_q <= drive_on;
         dom_q <= drive_on & ~txd;
         fault_q <= pending;
      end
   end
   assign pins.rxd = rxd_q;
   assign pins.bus_oe = oe_q;
   assign pins.bus_dominant_out = dom_q;
   assign pins.fault = fault_q;
   assign fault_pending = fault_q;
endmodule // xcvr_device

// File: hw/xcvr_ctrl.sv
// controller end: Avalon-MM slave for software, drives txd, reads code
// assumes device pins are asynchronous and synchronised here
`timescale 1ns/1ps
module xcvr_ctrl
   import xcvr_pkg::*;
(
   input  wire logic        core_clk,         // 20 MHz clock
   input  wire logic        arst_n,           // async reset, active low
   xcvr_if.ctrl             pins,             // device pins
   input  wire logic [3:0]  avs_address,      // byte address
   input  wire logic        avs_read,         // read request
   input  wire logic        avs_write,        // write request
   input  wire logic [31:0] avs_writedata,    // write data
   output logic      [31:0] avs_readdata,     // read data
   output logic             avs_waitrequest   // stall
);
   import xcvr_pkg::*;

   logic [1:0] s_rxd, s_flt;
   logic [31:0] ctrl;
   logic [5:0] code_rx;
   logic [CNT_W-1:0] pulses;
   logic [1:0] ph;
   logic txd_q, busy, done;
   ctl_state_t st;

   wire rxd = s_rxd[1];
   wire flt = s_flt[1];
   wire ack = ~avs_waitrequest;
   // a write lands only at the edge that sees waitrequest low
   wire wr = avs_write & ack;
   wire rd = avs_read & ~ack;
   wire tick = (ph == 2'(HALF_PERIOD - 1));
   // round trip through both synchronisers exceeds one pulse period:
   // the bit moved by one rise shows only before the rise after next
   wire grab = (st == C_READ) & ~txd_q & ((pulses == '0) |
               ((pulses >= 8'h02) & (pulses <= CNT_W'(CODE_W))));
   wire [CNT_W-1:0] target = (st == C_ARM) ? CNT_W'(ARM_EDGES) :
                             (st == C_READ) ? CNT_W'(SHIFT_EDGES) :
                             CNT_W'(CLEAR_EDGES);
   wire [31:0] status = {27'h0, done, busy, flt, pins.silent_select, rxd};
   wire [31:0] next_rd = (avs_address == OFS_CTRL) ? ctrl :
                         (avs_address == OFS_STATUS) ? status :
                         (avs_address == OFS_CODE) ? {26'h0, code_rx} : 32'h0;

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_rxd <= 2'h3;
         s_flt <= 2'h0;
      end else begin
         s_rxd <= {s_rxd[0], pins.rxd};
         s_flt <= {s_flt[0], pins.fault};
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & ~ack);
         if (rd) avs_readdata <= next_rd;
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl <= CTRL_RESET;
         st <= C_IDLE;
         ph <= 2'h0;
         pulses <= '0;
         txd_q <= 1'b1;
         busy <= 1'b0;
         done <= 1'b0;
         code_rx <= CODE_RESET;
      end else begin
         if (wr && avs_address == OFS_CTRL) begin
            ctrl <= avs_writedata;
            // refuse silent while a fault is pending
            if (flt) ctrl[CTRL_SIL] <= 1'b0;
         end
         case (st)
            C_IDLE: begin
               txd_q <= ctrl[CTRL_TXD];
               ph <= 2'h0;
               pulses <= '0;
               if (wr && avs_address == OFS_CTRL && avs_writedata[2:0] != 3'h0) begin
                  busy <= 1'b1;
                  done <= 1'b0;
                  st <= avs_writedata[CTRL_ARM] ? C_ARM :
                        avs_writedata[CTRL_READ] ? C_READ : C_CLEAR;
               end
            end
            C_ARM, C_READ, C_CLEAR: begin
               ph <= tick ? 2'h0 : ph + 2'h1;
               if (tick) begin
                  if (!txd_q) begin
                     txd_q <= 1'b1;
                     pulses <= pulses + 8'h01;
                  end else if (pulses == target) begin
                     // stay high: a last low phase would add one rise
                     st <= C_WAIT;
                  end else begin
                     txd_q <= 1'b0;
                  end
                  if (grab) code_rx <= {code_rx[4:0], rxd};
               end
            end
            C_WAIT: begin
               txd_q <= 1'b1;
               busy <= 1'b0;
               done <= 1'b1;
               st <= C_IDLE;
            end
            default: st <= C_IDLE;
         endcase
      end
   end

   logic standby_q, sil_q, lpb_q;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         standby_q <= 1'b0;
         sil_q <= 1'b0;
         lpb_q <= 1'b0;
      end else begin
         standby_q <= ctrl[CTRL_STANDBY];
         sil_q <= ctrl[CTRL_SIL] & ~flt;
         lpb_q <= ctrl[CTRL_LOOPBACK];
      end
   end
   assign pins.txd = txd_q;
   assign pins.standby_select = standby_q;
   assign pins.silent_select = sil_q;
   assign pins.loopback_select = lpb_q;
endmodule // xcvr_ctrl

// File: testbench/xcvr_monitor.sv
// concurrent checks on the pins joining controller end and transceiver end
// assumes one clock domain; watches only the shared interface signals
`timescale 1ns/1ps
module xcvr_monitor
   import xcvr_pkg::*;
(
   input wire logic core_clk,         // clock
   input wire logic arst_n,           // async reset, active low
   input wire logic txd,              // transmit data
   input wire logic rxd,              // receive data
   input wire logic fault,            // fault indicator
   input wire logic standby_select,   // standby mode
   input wire logic silent_select,    // silent mode
   input wire logic loopback_select,  // loopback mode
   input wire logic bus_dominant_in,  // resolved bus level
   input wire logic bus_dominant_out, // driver wants dominant
   input wire logic bus_oe,           // driver enabled
   input wire logic overcurrent,      // current comparator
   input wire logic overvoltage       // voltage comparator
);
   logic [7:0]  arm_cnt;
   logic [7:0]  clr_cnt;
   logic [15:0] low_cnt;
   logic        txd_q;
   logic        fault_q;
   wire         sel       = standby_select | silent_select | loopback_select;
   wire         rise      = txd & ~txd_q;
   // counts raw edges; device counts later through its synchroniser, so never less
   wire [7:0]   next_arm  = (sel | (fault_q & ~fault)) ? 8'h00
                                                       : arm_cnt + {7'h00, rise & ~&arm_cnt};
   wire [7:0]   next_clr  = ~fault ? 8'h00 : clr_cnt + {7'h00, rise & ~&clr_cnt};
   wire [15:0]  next_low  = txd ? 16'h0000 : low_cnt + {15'h0000, ~&low_cnt};
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         {txd_q, fault_q, arm_cnt, clr_cnt, low_cnt} <= {1'b1, 1'b0, 32'h0};
      end else begin
         {txd_q, fault_q, arm_cnt, clr_cnt, low_cnt} <= {txd, fault, next_arm, next_clr, next_low};
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   a_bus_released: assert property (fault [*3] |-> !bus_oe)
      else $error("bus still driven during fault");
   a_detect_modes: assert property ($rose(fault) |-> $past(!(standby_select || silent_select), 5))
      else $error("fault raised outside normal mode");
   a_arm_count: assert property ($rose(fault) |-> arm_cnt >= ARM_EDGES)
      else $error("fault raised before arming edges");
   a_clear_count: assert property ($fell(fault) |-> clr_cnt >= SHIFT_EDGES + CLEAR_EDGES)
      else $error("fault cleared too early");
   a_hold_in_modes: assert property ((fault && (standby_select || silent_select)) [*4] |=> fault)
      else $error("fault cleared in standby or silent");
   a_tx_off_modes: assert property ((standby_select || silent_select) [*4] |-> !(bus_oe && bus_dominant_out))
      else $error("transmitter active in standby or silent");
   a_loop_released: assert property (loopback_select [*4] |-> !bus_oe)
      else $error("bus driven in loopback");
   a_dom_timeout: assert property (low_cnt > DOM_CYCLES + 4 |-> !(bus_oe && bus_dominant_out))
      else $error("dominant held past timeout");
endmodule // xcvr_monitor

// File: testbench/testbench.sv
// self-checking bench: controller end and transceiver end joined by xcvr_if
// assumes a single 20 MHz clock; bench resolves the bus and drives comparators
`timescale 1ns/1ps
module testbench;
   import xcvr_pkg::*;
   logic        core_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        pend;
   logic        oc, ov, stuck, force_dom;
   logic [31:0] q;
   int          seed = 14430;
   int          bad_count = 0;
   int          comparisons = 0;
   int          cycles = 0;
   logic [7:0]  mode_v [5] = '{8'h20, 8'h60, 8'h10, 8'h08, 8'h48};
   logic        mode_rx [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   xcvr_if xif();
   // stuck models an open bus: driver has no effect on the sensed level
   assign xif.bus_dominant_in = force_dom | (~stuck & xif.bus_oe & xif.bus_dominant_out);
   assign xif.overcurrent = oc;
   assign xif.overvoltage = ov;
   xcvr_device i_xcvr_device (.core_clk(core_clk), .arst_n(arst_n), .pins(xif.device),
                              .fault_pending(pend));
   xcvr_ctrl i_xcvr_ctrl (.core_clk(core_clk), .arst_n(arst_n), .pins(xif.ctrl),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest));
   xcvr_monitor i_xcvr_monitor (.core_clk(core_clk), .arst_n(arst_n), .txd(xif.txd),
      .rxd(xif.rxd), .fault(xif.fault), .standby_select(xif.standby_select),
      .silent_select(xif.silent_select), .loopback_select(xif.loopback_select),
      .bus_dominant_in(xif.bus_dominant_in), .bus_dominant_out(xif.bus_dominant_out),
      .bus_oe(xif.bus_oe), .overcurrent(xif.overcurrent), .overvoltage(xif.overvoltage));
   always #25 core_clk = ~core_clk;
   task automatic complete_run;
      if (bad_count == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 40000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         bad_count++;
         $display("unexpected at %0t: seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
      @(posedge core_clk);
      {avs_address, avs_read, avs_write, avs_writedata} <= {a, ~w, w, d};
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      {avs_read, avs_write} <= 2'b00;
   endtask
   task automatic cmd(input logic [31:0] v);
      av(OFS_CTRL, 1'b1, v);
      do av(OFS_STATUS, 1'b0, 32'h0); while (q[3] === 1'b1);
   endtask
   task automatic inject(input int k, input logic on);
      @(posedge core_clk);
      if (k == 0) ov <= on;
      else if (k == 1) oc <= on;
      else begin
         // txd stays low on release, so no stray rise shifts the code
         stuck <= on;
         if (on) av(OFS_CTRL, 1'b1, 32'h0);
      end
   endtask
   function automatic logic [5:0] code_of(input int k);
      case (k)
         0: return 6'b101100;
         1: return 6'b101010;
         default: return 6'b110010;
      endcase
   endfunction
   initial begin
      {avs_address, avs_read, avs_write, avs_writedata} = '0;
      {oc, ov, stuck, force_dom} = 4'h0;
      repeat (10) @(posedge core_clk);
      arst_n <= 1'b1;
      av(OFS_CTRL, 1'b0, 32'h0);
      chk(q, 32'h40);
      av(4'hC, 1'b0, 32'h0);
      chk(q, 32'h0);
      av(OFS_CTRL, 1'b1, 32'h0);
      repeat (DOM_CYCLES + 20) @(posedge core_clk);
      chk(xif.bus_oe & xif.bus_dominant_out, 32'h0);
      av(OFS_CTRL, 1'b1, 32'h40);
      repeat (8) @(posedge core_clk);
      chk(xif.bus_oe, 32'h1);
      for (int j = 0; j < 5; j++) begin
         av(OFS_CTRL, 1'b1, {24'h0, mode_v[j]});
         force_dom <= (j == 4);
         repeat (40) @(posedge core_clk);
         av(OFS_STATUS, 1'b0, 32'h0);
         chk(q[0], mode_rx[j]);
      end
      force_dom <= 1'b0;
      av(OFS_CTRL, 1'b1, 32'h40);
      oc <= 1'b1;
      repeat (20) @(posedge core_clk);
      chk(xif.fault, 32'h0);
      oc <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         cmd(32'h41);
         repeat (($random(seed) & 7) + 1) @(posedge core_clk);
         inject(k % 3, 1'b1);
         for (int n = 0; n < 40 && xif.fault !== 1'b1; n++) @(posedge core_clk);
         if (k % 3 == 2) inject(2, 1'b0);
         // a later fault must not replace the latched code
         oc <= 1'b1;
         ov <= 1'b1;
         repeat (4) @(posedge core_clk);
         chk({pend, xif.fault, xif.bus_oe}, 32'h6);
         if (k == 3) begin
            cmd(32'h44);
            chk(xif.fault, 32'h1);
         end
         if (k == 1) begin
            cmd(32'h5C);
            chk(xif.fault, 32'h1);
            av(OFS_STATUS, 1'b0, 32'h0);
            chk(q[1], 1'b0);
            av(OFS_CTRL, 1'b1, 32'h40);
         end
         cmd(32'h42);
         av(OFS_CODE, 1'b0, 32'h0);
         if (k < 3) chk(q[5:0], code_of(k));
         oc <= 1'b0;
         ov <= 1'b0;
         cmd(32'h44);
         repeat (8) @(posedge core_clk);
         chk(xif.fault, 32'h0);
         oc <= 1'b1;
         repeat (20) @(posedge core_clk);
         chk(xif.fault, 32'h0);
         oc <= 1'b0;
      end
      complete_run();
   end
endmodule // testbench
